/* bench/bmrc_mcu_model.sv */
// Target pin model: mode pins with jumper pulls, mode latch, interrupt counter.
// Assumes the sequencer drives its reset, mode and interrupt pins directly.
`timescale 1ns/1ps
`default_nettype none
module bmrc_mcu_model #(
	parameter logic [3:0] USER_PINS = 4'ha
) (
	input wire logic reset_n_i, // Target reset
	input wire logic [3:0] mode_i, // Driven levels
	input wire logic [3:0] oe_i, // Drive enables
	input wire logic nmi_n_i, // Interrupt pin
	output logic [3:0] latched_o, // Mode at reset exit
	output logic [7:0] nmi_cnt_o // Interrupts seen
);
	logic [3:0] pins;
	initial latched_o = 4'h0;
	initial nmi_cnt_o = 8'h0;
	// Undriven pins fall to the jumper pulls, never a stale level
	assign pins = (mode_i & oe_i) | (USER_PINS & ~oe_i);
	// Mode is taken as reset lets go
	always @(posedge reset_n_i) latched_o <= pins;
	// Each falling edge is one interrupt
	always @(negedge nmi_n_i) nmi_cnt_o <= nmi_cnt_o + 8'h1;
endmodule
`default_nettype wire

/* bench/bmrc_top_properties.sv */
// Port checker for the reset sequencer, bound onto bmrc_top.
// Assumes one clock domain and synchronous reset rst_i.
`timescale 1ns/1ps
`default_nettype none
module bmrc_checker #(
	parameter int unsigned RESET_CYC = 50
) (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic reset_btn_n_i, // Reset button
	input wire logic boot_btn_n_i, // Boot button
	input wire logic nmi_btn_n_i, // Interrupt button
	input wire logic cts_n_i, // Host toggle
	input wire logic mcu_reset_n_o, // Target reset
	input wire logic [3:0] mode_o, // Mode values
	input wire logic [3:0] mode_oe_o, // Mode enables
	input wire logic mcu_nmi_n_o, // Interrupt
	input wire logic rts_o, // Mode report
	input wire logic boot_led_o // Boot lamp
);
	int unsigned low_cnt;
	// Length of the current reset period
	always_ff @(posedge clk_i)
	begin
		if (rst_i || mcu_reset_n_o)
			low_cnt <= 0;
		else
			low_cnt <= low_cnt + 1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence nmi_pulse;
		##19 !mcu_nmi_n_o ##1 mcu_nmi_n_o;
	endsequence
	a_mode_value: assert property (mode_o == 4'h2) else $error("mode value");
	a_oe_boot_only: assert property (mode_oe_o != 4'h0 |->
		mode_oe_o == 4'hf && (!mcu_reset_n_o || !$past(mcu_reset_n_o))
		&& (rts_o || $past(rts_o))) else $error("mode drive");
	a_oe_drop_after: assert property ($rose(mcu_reset_n_o) |=>
		mode_oe_o == 4'h0) else $error("mode drive left on");
	a_boot_entry: assert property ($rose(rts_o) |->
		!mcu_reset_n_o && mode_oe_o == 4'hf) else $error("boot entry");
	a_release_clean: assert property ($rose(mcu_reset_n_o) |->
		mode_oe_o == (rts_o ? 4'hf : 4'h0) && boot_led_o == rts_o) else $error("release");
	a_hold_length: assert property ($rose(mcu_reset_n_o) |->
		low_cnt >= RESET_CYC) else $error("short reset");
	a_led_boot_run: assert property (boot_led_o |->
		rts_o && mcu_reset_n_o) else $error("boot lamp");
	a_nmi_width: assert property ($fell(mcu_nmi_n_o) |-> nmi_pulse) else $error("nmi");
	a_nmi_user: assert property ($fell(mcu_nmi_n_o) |->
		mcu_reset_n_o && !rts_o) else $error("nmi mode");
	a_rst_entry: assert property (disable iff (1'b0) rst_i |=>
		!mcu_reset_n_o && !rts_o && mode_oe_o == 4'h0) else $error("power up");
endmodule
bind bmrc_top bmrc_checker #(.RESET_CYC(RESET_CYC)) bmrc_checker_inst (.clk_i(clk_i),
	.rst_i(rst_i), .reset_btn_n_i(reset_btn_n_i), .boot_btn_n_i(boot_btn_n_i),
	.nmi_btn_n_i(nmi_btn_n_i), .cts_n_i(cts_n_i), .mcu_reset_n_o(mcu_reset_n_o),
	.mode_o(mode_o), .mode_oe_o(mode_oe_o), .mcu_nmi_n_o(mcu_nmi_n_o), .rts_o(rts_o),
	.boot_led_o(boot_led_o));
`default_nettype wire

/* bench/bmrc_top_tb_top.sv */
// Testbench for the reset sequencer with the target pin model.
// Assumes shortened counts: reset 50 cycles, debounce 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module bmrc_top_tb_top;
	localparam int RST_N = 50;
	localparam logic [3:0] USER_PINS = 4'ha;
	logic clk, rst, rst_n_w, nmi_n_w, rts, led;
	logic [3:0] btn_n; // cts, nmi, boot, reset
	logic [3:0] md, md_oe, latched;
	logic [7:0] nmi_cnt;
	int err_count, samples_checked, n;
	bmrc_top #(.RESET_CYC(RST_N), .DEBOUNCE_CYC(4)) bmrc_top_inst (.clk_i(clk), .rst_i(rst),
		.reset_btn_n_i(btn_n[0]), .boot_btn_n_i(btn_n[1]), .nmi_btn_n_i(btn_n[2]),
		.cts_n_i(btn_n[3]), .mcu_reset_n_o(rst_n_w), .mode_o(md), .mode_oe_o(md_oe),
		.mcu_nmi_n_o(nmi_n_w), .rts_o(rts), .boot_led_o(led));
	bmrc_mcu_model #(.USER_PINS(USER_PINS)) bmrc_mcu_model_inst (.reset_n_i(rst_n_w),
		.mode_i(md), .oe_i(md_oe), .nmi_n_i(nmi_n_w), .latched_o(latched), .nmi_cnt_o(nmi_cnt));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Held low for h cycles; long holds keep the timer reloading
	task press(input int i, input int h);
		@(negedge clk);
		btn_n[i] = 1'b0;
		repeat (h) @(negedge clk);
		btn_n[i] = 1'b1;
	endtask
	task wait_rel;
		n = 0;
		while (rst_n_w !== 1'b1 && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
	endtask
	task end_of_test;
		$display("Checks %0d, errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task t_powerup;
		check(rst_n_w, 0);
		check(md_oe, 4'h0);
		wait_rel;
		check(n >= RST_N, 1);
		check(latched, USER_PINS);
	endtask
	task t_nmi;
		press(2, 30);
		repeat (30) @(negedge clk);
		check(nmi_cnt, 8'h1);
	endtask
	task t_boot;
		press(1, 120);
		check(rst_n_w, 0);
		check(rts, 1);
		check(md_oe, 4'hf);
		wait_rel;
		check(n >= RST_N, 1);
		check(latched, 4'h2);
		check(led, 1);
	endtask
	task t_cts;
		press(2, 10);
		repeat (30) @(negedge clk);
		check(nmi_cnt, 8'h1);
		press(3, 10);
		check(rts, 0);
		wait_rel;
		check(latched, USER_PINS);
		press(3, 10);
		wait_rel;
		check(latched, 4'h2);
	endtask
	task t_ignore;
		press(0, 10);
		check(rts, 0);
		repeat (20) @(negedge clk);
		press(1, 10);
		wait_rel;
		check(n >= RST_N, 1);
		check(latched, USER_PINS);
	endtask
	// Watchdog well beyond the expected run
	initial
	begin
		repeat (5000) @(posedge clk);
		err_count++;
		end_of_test;
	end
	initial
	begin
		btn_n = 4'hf;
		rst = 1'b1;
		err_count = 0;
		samples_checked = 0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		t_powerup;
		t_nmi;
		t_boot;
		t_cts;
		t_ignore;
		end_of_test;
	end
endmodule
`default_nettype wire

/* core/bmrc_debounce.sv */
// Debouncer for one active-low button or line, with two-stage synchroniser.
// Assumes the input is asynchronous to clk_i and bounces for less than the settle time.
`timescale 1ns/1ps
`default_nettype none

module bmrc_debounce #(
	parameter int unsigned SETTLE_CYC = 200000
) (
	input wire logic clk_i,      // System clock
	input wire logic rst_i,      // Synchronous reset, active high
	input wire logic pin_n_i,    // Raw active-low input
	output logic active_o,       // Debounced active level
	output logic press_o         // One-cycle pulse on activation
);

	localparam int CW = $clog2(SETTLE_CYC + 1);

	initial
	begin
		if (SETTLE_CYC < 1)
			$error("SETTLE_CYC must be at least 1");
	end

	logic sync_a;
	logic sync_b;
	logic [CW-1:0] cnt;

	// Two flip-flops before any logic reads the pin
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
		end
		else
		begin
			sync_a <= pin_n_i;
			sync_b <= sync_a;
		end
	end

	// Accept a new level only after it has stood for the settle time
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt <= '0;
			active_o <= 1'b0;
			press_o <= 1'b0;
		end
		else
		begin
			press_o <= 1'b0;
			if ((!sync_b) == active_o)
				cnt <= '0;
			else if (cnt == CW'(SETTLE_CYC - 1))
			begin
				cnt <= '0;
				active_o <= !sync_b;
				press_o <= !sync_b;
			end
			else
				cnt <= cnt + 1'b1;
		end
	end

endmodule

`default_nettype wire

/* core/bmrc_map.svh */
// Constants for the boot mode reset controller: timing counts and fixed mode settings.
// Assumes a 20 MHz system clock; included by the package users by bare name.
`ifndef BMRC_MAP_SVH
`define BMRC_MAP_SVH

// System clock rate in Hz
`define BMRC_CLK_HZ 20000000
// Reset hold time after last control release, in ms (over 500 ms)
`define BMRC_RESET_MS 510
// Reset hold count in cycles, cycles per ms rounded down
`define BMRC_RESET_CYC ((`BMRC_CLK_HZ / 1000) * `BMRC_RESET_MS)
// Button debounce time in ms and derived cycle count
`define BMRC_DEBOUNCE_MS 10
`define BMRC_DEBOUNCE_CYC ((`BMRC_CLK_HZ / 1000) * `BMRC_DEBOUNCE_MS)
// Interrupt pulse width in cycles
`define BMRC_NMI_PULSE_CYC 20
// Mode pin width and fixed boot mode 2 pattern
`define BMRC_MODE_W 4
`define BMRC_BOOT_MODE 4'h2

`endif

/* core/bmrc_pkg.sv */
// Types for the boot mode reset controller.
// No assumptions beyond the map header.
package bmrc_pkg;

	// Four sequencing states: reset and run for each mode
	typedef enum logic [1:0] {
		BMRC_USER_RST,
		BMRC_USER_RUN,
		BMRC_BOOT_RST,
		BMRC_BOOT_RUN
	} bmrc_state_t;

	// Debounced control events: one-cycle press pulses and a held level
	typedef struct packed {
		logic boot_press;
		logic reset_press;
		logic nmi_press;
		logic held;
	} bmrc_events_t;

	// Mode pin drive bundle
	typedef struct packed {
		logic [3:0] value;
		logic [3:0] oe;
	} bmrc_mode_drive_t;

endpackage

/* core/bmrc_top.sv */
// Boot mode reset controller: sequences reset, mode pins and interrupt of the target.
// Assumes buttons and the clear-to-send line are asynchronous active-low pins;
// the board resolves mode pin levels from the enables and the user-mode pull jumpers.
`include "bmrc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module bmrc_top #(
	parameter int unsigned RESET_CYC = `BMRC_RESET_CYC,       // Reset hold after release
	parameter int unsigned DEBOUNCE_CYC = `BMRC_DEBOUNCE_CYC  // Button settle time
) (
	input wire logic clk_i,                 // 20 MHz board clock
	input wire logic rst_i,                 // Power-up reset, active high, synchronous
	input wire logic reset_btn_n_i,         // Reset button, active low
	input wire logic boot_btn_n_i,          // Boot button, active low
	input wire logic nmi_btn_n_i,           // Interrupt button, active low
	input wire logic cts_n_i,               // Clear-to-send from host, active low
	output logic mcu_reset_n_o,             // Target reset, active low
	output logic [3:0] mode_o,              // Mode pin drive values
	output logic [3:0] mode_oe_o,           // Mode pin enables, high while driving
	output logic mcu_nmi_n_o,               // Target interrupt, active low
	output logic rts_o,                     // Ready-to-send: high boot, low user
	output logic boot_led_o                 // Boot mode indicator, high lit
);

	localparam int TW = $clog2(RESET_CYC + 1);
	localparam int PW = $clog2(`BMRC_NMI_PULSE_CYC + 1);

	initial
	begin
		if (RESET_CYC < 1)
			$error("RESET_CYC must be at least 1");
	end

	bmrc_pkg::bmrc_state_t state;
	bmrc_pkg::bmrc_state_t next_state;
	bmrc_pkg::bmrc_events_t ev;
	bmrc_pkg::bmrc_mode_drive_t next_drive;
	logic [TW-1:0] timer;
	logic timer_done;
	logic [PW-1:0] nmi_cnt;
	logic rst_act;
	logic boot_act;
	logic cts_act;
	logic boot_evt;
	logic cts_evt;

	// One debouncer per control input
	bmrc_debounce #(.SETTLE_CYC(DEBOUNCE_CYC)) u_db_rst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_n_i(reset_btn_n_i),
		.active_o(rst_act),
		.press_o(ev.reset_press)
	);

	bmrc_debounce #(.SETTLE_CYC(DEBOUNCE_CYC)) u_db_boot (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_n_i(boot_btn_n_i),
		.active_o(boot_act),
		.press_o(boot_evt)
	);

	bmrc_debounce #(.SETTLE_CYC(DEBOUNCE_CYC)) u_db_cts (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_n_i(cts_n_i),
		.active_o(cts_act),
		.press_o(cts_evt)
	);

	bmrc_debounce #(.SETTLE_CYC(DEBOUNCE_CYC)) u_db_nmi (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_n_i(nmi_btn_n_i),
		.active_o(),
		.press_o(ev.nmi_press)
	);

	// Host line low acts like the boot button
	assign ev.boot_press = boot_evt | cts_evt;
	assign ev.held = rst_act | boot_act | cts_act;
	assign timer_done = (timer == '0);

	// Reset timer: reloads on power-up, on each reset or boot press and while a reset, boot or host input is held
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			timer <= TW'(RESET_CYC);
		else if (ev.held || ev.reset_press || ev.boot_press)
			timer <= TW'(RESET_CYC);
		else if (!timer_done)
			timer <= timer - 1'b1;
	end

	// State transitions; a boot press inside a reset period leaves the state unchanged
	always_comb
	begin
		next_state = state;
		unique case (state)
			bmrc_pkg::BMRC_USER_RST:
			begin
				if (timer_done && !ev.held)
					next_state = bmrc_pkg::BMRC_USER_RUN;
			end
			bmrc_pkg::BMRC_BOOT_RST:
			begin
				if (ev.reset_press)
					next_state = bmrc_pkg::BMRC_USER_RST;
				else if (timer_done && !ev.held)
					next_state = bmrc_pkg::BMRC_BOOT_RUN;
			end
			bmrc_pkg::BMRC_USER_RUN:
			begin
				if (ev.reset_press)
					next_state = bmrc_pkg::BMRC_USER_RST;
				else if (ev.boot_press)
					next_state = bmrc_pkg::BMRC_BOOT_RST;
			end
			bmrc_pkg::BMRC_BOOT_RUN:
			begin
				// A boot event toggles back to user mode
				if (ev.reset_press || ev.boot_press)
					next_state = bmrc_pkg::BMRC_USER_RST;
			end
		endcase
	end

	// Four-state sequencer; power-up starts in user reset
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state <= bmrc_pkg::BMRC_USER_RST;
		else
			state <= next_state;
	end

	// Mode pins driven in boot reset and for one cycle after it, floated elsewhere for the jumpers
	always_comb
	begin
		next_drive.value = `BMRC_BOOT_MODE;
		next_drive.oe = '0;
		// Drive stays one cycle past reset release so the target latches a held level
		if (next_state == bmrc_pkg::BMRC_BOOT_RST || state == bmrc_pkg::BMRC_BOOT_RST)
			next_drive.oe = '1;
	end

	// Registered reset, mode and status outputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mcu_reset_n_o <= 1'b0;
			mode_o <= `BMRC_BOOT_MODE;
			mode_oe_o <= '0;
			rts_o <= 1'b0;
			boot_led_o <= 1'b0;
		end
		else
		begin
			// Reset stays low in both reset states while mode pins settle
			mcu_reset_n_o <= (next_state == bmrc_pkg::BMRC_USER_RUN)
				|| (next_state == bmrc_pkg::BMRC_BOOT_RUN);
			mode_o <= next_drive.value;
			mode_oe_o <= next_drive.oe;
			rts_o <= (next_state == bmrc_pkg::BMRC_BOOT_RST)
				|| (next_state == bmrc_pkg::BMRC_BOOT_RUN);
			boot_led_o <= (next_state == bmrc_pkg::BMRC_BOOT_RUN);
		end
	end

	// Interrupt pulse: one fixed-width low pulse per debounced press in user run while no pulse is running
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			nmi_cnt <= '0;
			mcu_nmi_n_o <= 1'b1;
		end
		else if (ev.nmi_press && state == bmrc_pkg::BMRC_USER_RUN
			&& next_state == bmrc_pkg::BMRC_USER_RUN && nmi_cnt == '0)
		begin
			nmi_cnt <= PW'(`BMRC_NMI_PULSE_CYC);
			mcu_nmi_n_o <= 1'b0;
		end
		else if (nmi_cnt != '0)
		begin
			nmi_cnt <= nmi_cnt - 1'b1;
			mcu_nmi_n_o <= (nmi_cnt == PW'(1));
		end
	end

endmodule

`default_nettype wire
